// file: ram_fifo_block.v
// One embedded memory block usable as dual-clock RAM or FIFO, with cascade select
`timescale 1ns/1ps
`default_nettype none
`include "ram_fifo_defs.vh"
// Overview of operation
// - Block holds 4608 bits, has its own FIFO controller, RAM or FIFO mode.
// - Reads and writes are synchronous; addresses, data and enables sampled on edges.
// - Write clock and read clock are independent in frequency and phase.
// - FIFO mode generates addresses and drives full, empty, almost flags.
// - Pointers cross domains synchronised; writes when full, reads when empty blocked.
// - RAM mode uses user read and write addresses; FIFO controller ignored.
// - FIFO mode muxes controller addresses to the array instead of user addresses.
// - Select enables of programmable polarity act as upper address bits, 16 blocks.
// - Cascaded blocks share write/read address, data and enable buses internally.
// - Cascading uses dedicated column routing, no general logic.
module ram_fifo_block (
  input  wire                    clk,
  input  wire                    srst,
  input  wire                    readClk,
  input  wire                    fifoMode,
  input  wire                    pipelineEn,
  input  wire [`RF_PTR_W-1:0]    almostFullLevel,
  input  wire [`RF_PTR_W-1:0]    almostEmptyLevel,
  input  wire [`RF_ADDR_W-1:0]   writeAddr,
  input  wire [`RF_DATA_W-1:0]   writeDataIn,
  input  wire                    writeEn,
  input  wire [`RF_SEL_W-1:0]    writeSel,
  input  wire [`RF_SEL_W-1:0]    writeSelPol,
  input  wire [`RF_ADDR_W-1:0]   readAddr,
  input  wire                    readEn,
  input  wire [`RF_SEL_W-1:0]    readSel,
  input  wire [`RF_SEL_W-1:0]    readSelPol,
  input  wire [`RF_DATA_W-1:0]   readDataCascIn,
  output reg  [`RF_DATA_W-1:0]   readData,
  output reg                     fullFlag,
  output reg                     emptyFlag,
  output reg                     almostFullFlag,
  output reg                     almostEmptyFlag
);

  function [`RF_PTR_W-1:0] bin2gray;
    input [`RF_PTR_W-1:0] b;
    begin
      bin2gray = b ^ (b >> 1);
    end
  endfunction

  function [`RF_PTR_W-1:0] gray2bin;
    input [`RF_PTR_W-1:0] g;
    integer i;
    begin
      gray2bin[`RF_PTR_W-1] = g[`RF_PTR_W-1];
      for (i = `RF_PTR_W - 2; i >= 0; i = i - 1) begin
        gray2bin[i] = gray2bin[i+1] ^ g[i];
      end
    end
  endfunction

  // ==========================================================
  // Storage array
  // ==========================================================
  reg  [`RF_DATA_W-1:0] mem [0:`RF_DEPTH-1];

  // ==========================================================
  // Read-domain reset
  // ==========================================================
  wire readRst;

  sync_stage3 #(.W(1)) rstSync (
    .clk  (readClk),
    .srst (1'b0),
    .d    (srst),
    .q    (readRst)
  );

  // ==========================================================
  // Gray pointers handed across the clock boundary
  // ==========================================================
  // Declared ahead of both domains since each synchroniser reads the other's copy
  reg  [`RF_PTR_W-1:0]  wGray_q;
  reg  [`RF_PTR_W-1:0]  rGray_q;

  // ==========================================================
  // Write domain
  // ==========================================================
  reg  [`RF_PTR_W-1:0]  wPtr_q;
  wire [`RF_PTR_W-1:0]  rGraySyncW;
  wire                  writeHit;
  wire                  writeDo;
  wire [`RF_ADDR_W-1:0] writeIdx;
  wire [`RF_PTR_W-1:0]  wPtr_d;
  wire [`RF_PTR_W-1:0]  wCount;
  wire                  writeBlocked;
  wire                  fullNext;
  wire                  almostFullNext;

  // Each select bit must match its polarity, decoding the upper address
  assign writeHit     = &(writeSel ~^ writeSelPol);
  // A full FIFO drops the write; RAM mode never blocks
  assign writeBlocked = fifoMode & fullFlag;
  // Shared buses of a cascade arrive on the same ports of every block
  assign writeDo  = writeEn & writeHit & ~writeBlocked;
  assign writeIdx = fifoMode ? wPtr_q[`RF_ADDR_W-1:0] : writeAddr;
  assign wPtr_d   = wPtr_q + {{(`RF_PTR_W-1){1'b0}}, writeDo & fifoMode};
  assign wCount   = wPtr_d - gray2bin(rGraySyncW);

  // ==========================================================
  // Write-side flags
  // ==========================================================
  // Pessimistic: the read pointer seen here lags, so full releases late, never early
  assign fullNext       = (wCount == `RF_FULL_COUNT);
  // Level is compared against the count after this edge's write
  assign almostFullNext = (wCount >= almostFullLevel);

  sync_stage3 #(.W(`RF_PTR_W)) rPtrSync (
    .clk  (clk),
    .srst (srst),
    .d    (rGray_q),
    .q    (rGraySyncW)
  );

  always @(posedge clk) begin
    if (writeDo) begin
      mem[writeIdx] <= writeDataIn;
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      wPtr_q         <= `RF_PTR_RST;
      wGray_q        <= `RF_PTR_RST;
      fullFlag       <= `RF_FULL_RST;
      almostFullFlag <= `RF_ALMOST_FULL_FLAG_RST;
    end else begin
      wPtr_q         <= wPtr_d;
      wGray_q        <= bin2gray(wPtr_d);
      fullFlag       <= fullNext;
      almostFullFlag <= almostFullNext;
    end
  end

  // ==========================================================
  // Read domain
  // ==========================================================
  reg  [`RF_PTR_W-1:0]  rPtr_q;
  reg  [`RF_DATA_W-1:0] rdStage_q;
  reg  [`RF_DATA_W-1:0] readData_d;
  reg                   rdHit_q;
  wire [`RF_PTR_W-1:0]  wGraySyncR;
  wire                  readHit;
  wire                  readDo;
  wire [`RF_ADDR_W-1:0] readIdx;
  wire [`RF_PTR_W-1:0]  rPtr_d;
  wire [`RF_PTR_W-1:0]  rCount;
  wire                  readBlocked;
  wire                  emptyNext;
  wire                  almostEmptyNext;

  // Select decode mirrors the write side
  assign readHit     = &(readSel ~^ readSelPol);
  // An empty FIFO ignores the read and its pointer holds
  assign readBlocked = fifoMode & emptyFlag;
  assign readDo  = readEn & readHit & ~readBlocked;
  assign readIdx = fifoMode ? rPtr_q[`RF_ADDR_W-1:0] : readAddr;
  assign rPtr_d  = rPtr_q + {{(`RF_PTR_W-1){1'b0}}, readDo & fifoMode};
  assign rCount  = gray2bin(wGraySyncR) - rPtr_d;

  // ==========================================================
  // Read-side flags
  // ==========================================================
  // The write pointer seen here lags, so empty releases late, never early
  assign emptyNext       = (rCount == `RF_PTR_RST);
  assign almostEmptyNext = (rCount <= almostEmptyLevel);

  // ==========================================================
  // Read data path
  // ==========================================================
  // Unselected blocks pass the column's read data along the cascade
  always @* begin
    // Holding the old word keeps non-pipelined data standing until the next read
    readData_d = readData;
    if (pipelineEn) begin
      readData_d = rdHit_q ? rdStage_q : readDataCascIn;
    end else if (readDo) begin
      readData_d = mem[readIdx];
    end else if (~readHit) begin
      readData_d = readDataCascIn;
    end
  end

  sync_stage3 #(.W(`RF_PTR_W)) wPtrSync (
    .clk  (readClk),
    .srst (readRst),
    .d    (wGray_q),
    .q    (wGraySyncR)
  );

  always @(posedge readClk) begin
    if (readRst) begin
      rPtr_q          <= `RF_PTR_RST;
      rGray_q         <= `RF_PTR_RST;
      rdStage_q       <= `RF_DATA_RST;
      rdHit_q         <= 1'b0;
      readData        <= `RF_DATA_RST;
      emptyFlag       <= `RF_EMPTY_RST;
      almostEmptyFlag <= `RF_ALMOST_EMPTY_FLAG_RST;
    end else begin
      rPtr_q          <= rPtr_d;
      rGray_q         <= bin2gray(rPtr_d);
      emptyFlag       <= emptyNext;
      almostEmptyFlag <= almostEmptyNext;
      if (readDo) begin
        rdStage_q <= mem[readIdx];
      end
      rdHit_q         <= readHit;
      readData        <= readData_d;
    end
  end

endmodule // ram_fifo_block
`default_nettype wire

// file: ram_fifo_defs.vh
// Constants for the embedded RAM/FIFO block
`ifndef RAM_FIFO_DEFS_VH
`define RAM_FIFO_DEFS_VH
// 18 x 256 = 4608 bits of storage
`define RF_DATA_W        18
`define RF_DEPTH         256
`define RF_ADDR_W        8
`define RF_PTR_W         9
`define RF_SEL_W         4
`define RF_FULL_COUNT    9'h100
`define RF_PTR_RST       9'h000
`define RF_DATA_RST      18'h00000
`define RF_EMPTY_RST     1'b1
`define RF_FULL_RST      1'b0
`define RF_ALMOST_FULL_FLAG_RST     1'b0
`define RF_ALMOST_EMPTY_FLAG_RST    1'b1
`endif

// file: sync_stage3.v
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module sync_stage3 #(
  parameter W = 1
) (
  input  wire         clk,
  input  wire         srst,
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);
  reg [W-1:0] s1_q;
  reg [W-1:0] s2_q;
  reg [W-1:0] s3_q;

  always @(posedge clk) begin
    if (srst) begin
      s1_q <= {W{1'b0}};
      s2_q <= {W{1'b0}};
      s3_q <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      // Gray-coded words move one bit at a time, so agreement means a settled value
      if (s2_q == s3_q) begin
        q <= s3_q;
      end
    end
  end
endmodule // sync_stage3
`default_nettype wire

// file: ram_fifo_block_props.sv
// Assertion checker for the embedded RAM/FIFO block
`timescale 1ns/1ps
`default_nettype none
`include "ram_fifo_defs.vh"
// ====
// Flag and read-port checks
module ram_fifo_block_props (
  input wire logic                  clk,
  input wire logic                  srst,
  input wire logic                  readClk,
  input wire logic                  fifoMode,
  input wire logic                  pipelineEn,
  input wire logic                  writeEn,
  input wire logic                  readEn,
  input wire logic [`RF_SEL_W-1:0]  writeSel,
  input wire logic [`RF_SEL_W-1:0]  writeSelPol,
  input wire logic [`RF_SEL_W-1:0]  readSel,
  input wire logic [`RF_SEL_W-1:0]  readSelPol,
  input wire logic [`RF_PTR_W-1:0]  almostFullLevel,
  input wire logic [`RF_DATA_W-1:0] readDataCascIn,
  input wire logic [`RF_DATA_W-1:0] readData,
  input wire logic                  fullFlag,
  input wire logic                  emptyFlag,
  input wire logic                  almostFullFlag,
  input wire logic                  almostEmptyFlag
);
  a_full_by_write: assert property (@(posedge clk) disable iff (srst)
    $rose(fullFlag) |-> $past(writeEn && fifoMode && writeSel == writeSelPol)) else $error("full rose idle");
  a_almost_full_flag_at_full: assert property (@(posedge clk) disable iff (srst)
    fullFlag && $stable(almostFullLevel) && almostFullLevel <= 9'h100 |-> almostFullFlag) else $error("almost_full_flag low");
  a_ram_full_hold: assert property (@(posedge clk) disable iff (srst)
    !fifoMode && $past(!fifoMode) |-> $stable({fullFlag, almostFullFlag})) else $error("ram wflag moved");
  a_empty_by_read: assert property (@(posedge readClk) disable iff (srst)
    $rose(emptyFlag) |-> $past(readEn && fifoMode && readSel == readSelPol)) else $error("empty rose idle");
  a_almost_empty_flag_at_empty: assert property (@(posedge readClk) disable iff (srst)
    emptyFlag |-> almostEmptyFlag) else $error("almost_empty_flag low");
  a_ram_empty_hold: assert property (@(posedge readClk) disable iff (srst)
    !fifoMode && $past(!fifoMode) |-> $stable({emptyFlag, almostEmptyFlag})) else $error("ram rflag moved");
  a_casc_follow: assert property (@(posedge readClk) disable iff (srst)
    readSel != readSelPol && !pipelineEn |=> readData == $past(readDataCascIn)) else $error("cascade lost");
  a_rdata_hold: assert property (@(posedge readClk) disable iff (srst)
    readSel == readSelPol && !readEn && !pipelineEn |=> $stable(readData)) else $error("read data moved");
endmodule // ram_fifo_block_props
bind ram_fifo_block ram_fifo_block_props ram_fifo_block_props_i (
  .clk             (clk),
  .srst            (srst),
  .readClk         (readClk),
  .fifoMode        (fifoMode),
  .pipelineEn      (pipelineEn),
  .writeEn         (writeEn),
  .readEn          (readEn),
  .writeSel        (writeSel),
  .writeSelPol     (writeSelPol),
  .readSel         (readSel),
  .readSelPol      (readSelPol),
  .almostFullLevel (almostFullLevel),
  .readDataCascIn  (readDataCascIn),
  .readData        (readData),
  .fullFlag        (fullFlag),
  .emptyFlag       (emptyFlag),
  .almostFullFlag  (almostFullFlag),
  .almostEmptyFlag (almostEmptyFlag)
);
`default_nettype wire

// file: fifo_user_model.sv
// Read-side user logic model for the RAM/FIFO block
`timescale 1ns/1ps
`default_nettype none
`include "ram_fifo_defs.vh"
// ====
// Consumer that can stall and, unless greedy is set, never reads an empty FIFO
module fifo_user_model (
  input  wire logic                  readClk,
  input  wire logic                  go,
  input  wire logic                  stall,
  input  wire logic                  greedy,
  input  wire logic                  fifoMode,
  input  wire logic                  pipelineEn,
  input  wire logic                  emptyFlag,
  input  wire logic [`RF_DATA_W-1:0] readData,
  output var  logic                  readEn = 1'b0,
  output var  logic [`RF_DATA_W-1:0] got = 18'h00000,
  output var  logic [15:0]           nGot = 16'h0000
);
  logic pend = 1'b0;
  // Capture half a cycle after the edge so the word has settled
  always @(negedge readClk) begin
    if (pipelineEn ? pend : readEn) begin
      got <= readData;
      nGot <= nGot + 16'h0001;
    end
    pend <= readEn;
    // Greedy ignores empty so the bench can prove reads of an empty FIFO are refused
    readEn <= go && !stall && (greedy || !(fifoMode && emptyFlag));
  end
endmodule // fifo_user_model
`default_nettype wire

// file: ram_fifo_block_tb.sv
// Self-checking testbench for the embedded RAM/FIFO block
`timescale 1ns/1ps
`default_nettype none
`include "ram_fifo_defs.vh"
// ====
// Bench
module ram_fifo_block_tb;
  logic clk = 0, srst = 1, readClk = 0, fifoMode = 1, pipelineEn = 0, writeEn = 0, readEn, go = 0, stall = 0;
  logic greedy = 0;
  logic [`RF_PTR_W-1:0]  almostFullLevel = 9'h0FC, almostEmptyLevel = 9'h002;
  logic [`RF_ADDR_W-1:0] writeAddr = 8'h00, readAddr = 8'h00;
  logic [`RF_DATA_W-1:0] writeDataIn = 18'h00000, readDataCascIn = 18'h00000, readData, got;
  logic [`RF_SEL_W-1:0]  writeSel = 4'h5, writeSelPol = 4'h5, readSel = 4'h5, readSelPol = 4'h5;
  logic                  fullFlag, emptyFlag, almostFullFlag, almostEmptyFlag;
  logic [15:0]           nGot;
  int mismatches = 0, checks = 0;
  ram_fifo_block ram_fifo_block_i (.*);
  fifo_user_model fifo_user_model_i (.*);
  initial forever #5 clk = ~clk;
  initial forever #3.5 readClk = ~readClk;
  task chk(input string n, input logic [`RF_DATA_W-1:0] s, e);
    checks++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input logic [`RF_DATA_W-1:0] d);
    writeEn = 1;
    writeDataIn = d;
    writeAddr = d[7:0];
    @(negedge clk);
  endtask
  // Reads n words; the k-th must be base + k
  task rd(input int n, input logic [`RF_DATA_W-1:0] base);
    int s, c, t;
    s = nGot;
    c = s;
    go = 1;
    for (t = 0; t < 4000 && c < s + n; t++) begin
      @(posedge readClk);
      if (nGot != c) begin
        c++;
        chk("read word", got, base + 18'(c - s));
      end
    end
    if (c < s + n) begin
      mismatches++;
      stop_test;
    end else begin
      go = 0;
      @(negedge clk);
    end
  endtask
  task t_fifo;
    int i;
    for (i = 1; i <= 3; i++) wr(18'h30000 + 18'(i));
    writeEn = 0;
    rd(3, 18'h30000);
    greedy = 1;
    go = 1;
    repeat (20) @(negedge clk);
    chk("underflow data", got, 18'h30003);
    chk("underflow flags", {emptyFlag, almostEmptyFlag}, 2'b11);
    go = 0;
    greedy = 0;
    repeat (3) @(negedge clk);
    wr(18'h30004);
    writeEn = 0;
    rd(1, 18'h30003);
  endtask
  task t_full;
    int i;
    for (i = 1; i <= 256; i++) begin
      wr(18'(i));
      chk("almost full", almostFullFlag, i >= 252);
    end
    wr(18'h3FFFF);
    writeEn = 0;
    chk("full", {fullFlag, almostFullFlag}, 2'b11);
    stall = 1;
    go = 1;
    i = nGot;
    repeat (10) @(negedge clk);
    chk("stalled", nGot, 16'(i));
    stall = 0;
    rd(256, 18'h00000);
    repeat (20) @(negedge clk);
    chk("drained", {nGot, emptyFlag, fullFlag}, {16'(i + 256), 2'b10});
  endtask
  task t_ram;
    fifoMode = 0;
    wr(18'h2AAAA);
    writeSelPol = 4'hA;
    wr(18'h155AA);
    writeEn = 0;
    writeSelPol = 4'h5;
    readAddr = 8'hAA;
    rd(1, 18'h2AAA9);
    pipelineEn = 1;
    rd(1, 18'h2AAA9);
    pipelineEn = 0;
  endtask
  task t_casc;
    readSelPol = 4'h0;
    readDataCascIn = 18'h1C3A5;
    repeat (3) @(negedge clk);
    chk("cascade", readData, 18'h1C3A5);
  endtask
  initial begin
    repeat (5) @(negedge clk);
    srst = 0;
    repeat (10) @(negedge clk);
    chk("reset flags", {fullFlag, almostFullFlag, emptyFlag, almostEmptyFlag}, 4'h3);
    t_fifo;
    t_full;
    t_ram;
    t_casc;
    stop_test;
  end
endmodule // ram_fifo_block_tb
`default_nettype wire
